// file: common/ofsr_regs.svh
// register offsets, field positions and timing constants for output fault status
`ifndef OFSR_REGS_SVH
`define OFSR_REGS_SVH
// ==========================================
// register byte addresses
`define OFSR_STATUS_ADDR      8'h00
`define OFSR_CTRL_BASE        8'h40
`define OFSR_GLOBAL_ADDR      8'h80
`define OFSR_IRQ_STAT_ADDR    8'h84
`define OFSR_IRQ_MASK_ADDR    8'h88
`define OFSR_SUPPLY_ADDR      8'h8c
// ==========================================
// status field positions
`define OFSR_BIT_OVL          4
`define OFSR_BIT_MODE         5
`define OFSR_BIT_SAFE         6
`define OFSR_BIT_SWOFF        7
`define OFSR_BIT_SUPPLY       8
// control word fields: [0] command on, [3:1] mode, [4] safety switch request
`define OFSR_CTL_CMD          0
`define OFSR_CTL_MODE_LO      1
`define OFSR_CTL_MODE_HI      3
`define OFSR_CTL_SW           4
// ==========================================
// timing
`define OFSR_HOLD_MS          250
`define OFSR_CLK_HZ           25000000
// divide first: the plain product overflows a 32-bit int
`define OFSR_HOLD_CYC         (`OFSR_HOLD_MS * (`OFSR_CLK_HZ / 1000))
`endif

// file: common/ofsr_pkg.sv
// types shared by the output fault status block
package ofsr_pkg;
   // ==========================================
   // output mode encodings; codes above 3 are invalid
   typedef enum logic [2:0] {
      OFSR_MODE_DIGITAL = 3'h0,
      OFSR_MODE_OPEN    = 3'h1,
      OFSR_MODE_CLOSED  = 3'h2,
      OFSR_MODE_SINK    = 3'h3
   } ofsr_mode_t;
   // per-output overload recovery states
   typedef enum logic [2:0] {
      OFSR_OV_RUN  = 3'b001,
      OFSR_OV_TRIP = 3'b010,
      OFSR_OV_HOLD = 3'b100
   } ofsr_ov_state_t;
endpackage : ofsr_pkg

// file: logic/ofsr_hold_timer.sv
// hold-off timer: counts a condition held continuously for a set number of cycles
`timescale 1ns/10ps
`default_nettype none
`include "ofsr_regs.svh"
module ofsr_hold_timer #(
   parameter int CYCLES = `OFSR_HOLD_CYC
) (
   input  wire logic sys_clk_i,
   input  wire logic resetn_i,
   input  wire logic run_i,
   output var  logic done_o
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   logic [W-1:0] cnt_q;
   wire          at_end = (cnt_q == LAST);
   // a drop of run restarts the count: the hold must be unbroken
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q  <= '0;
         done_o <= 1'b0;
      end else if (!run_i) begin
         cnt_q  <= '0;
         done_o <= 1'b0;
      end else if (!at_end) begin
         cnt_q  <= cnt_q + W'(1);
         done_o <= (cnt_q == LAST - W'(1));
      end else begin
         done_o <= 1'b1;
      end
   end
endmodule : ofsr_hold_timer
`default_nettype wire

// file: logic/ofsr_top.sv
// per-output fault status, recovery sequencing and redundant switch control
// ==========================================
// Summary of operation
// R1: on overload an output is disabled by the block and its bit 4 status flag is raised.
// R2: to recover from overload software holds the output commanded off for at least 250 ms.
// R3: after that unbroken off hold the block clears bit 4; the output drives again once commanded on.
// R4: bit 5 is raised while an invalid mode is selected and clears when a valid one is chosen.
// R5: only writing a valid mode clears the invalid-mode flag.
// R6: a safety-layer failure sets bit 6, which stays set until power-on reset.
// R7: when the secondary turns a safety switch off bit 7 is set and the switch stays off 250 ms.
// R8: the primary must command the affected output off before the switch may be restored.
// R9: the secondary may re-enable the switch only after 250 ms and with the output off.
// R10: on supply out of range (bit 8) the primary commands all outputs off.
// R11: bit 8 clears only when the supply is good again and all outputs are commanded off.
// R12: the secondary can disconnect each output's high-side switch separately at any time.
// R13: the secondary can drive and read back every redundant sourcing stage.
// R14: the secondary sees a digital supply-good indication.
// R15: a closed-loop overcurrent shuts the output down and latches it until the command is zero.
// R16: status positions other than 4 to 8 read as zero and status is readable at any time.
`timescale 1ns/10ps
`default_nettype none
`include "ofsr_regs.svh"
module ofsr_top #(
   parameter int N_OUT    = 4,
   parameter int HOLD_CYC = `OFSR_HOLD_CYC
) (
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   input  wire logic [7:0]       avs_address_i,
   input  wire logic             avs_read_i,
   input  wire logic             avs_write_i,
   input  wire logic [31:0]      avs_writedata_i,
   input  wire logic [3:0]       avs_byteenable_i,
   output var  logic [31:0]      avs_readdata_o,
   output var  logic             avs_waitrequest_o,
   input  wire logic [N_OUT-1:0] overload_i,
   input  wire logic [N_OUT-1:0] overcurrent_i,
   input  wire logic [N_OUT-1:0] safe_fail_i,
   input  wire logic [N_OUT-1:0] switch_fb_i,
   input  wire logic             supply_ok_i,
   output var  logic [N_OUT-1:0] proportional_switched_output_en_o,
   output var  logic [N_OUT-1:0] safety_switch_o,
   output var  logic             irq_o
);
   // ==========================================
   // input synchronisers
   logic [N_OUT-1:0] ovl_m_q, ovl_s_q, oc_m_q, oc_s_q, sf_m_q, sf_s_q, fb_m_q, fb_s_q;
   logic             sup_m_q, sup_s_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {ovl_m_q, ovl_s_q, oc_m_q, oc_s_q} <= '0;
         {sf_m_q, sf_s_q, fb_m_q, fb_s_q}   <= '0;
         // good level at reset, so no false supply fault follows it
         {sup_m_q, sup_s_q}                 <= 2'b11;
      end else begin
         ovl_m_q <= overload_i;
         ovl_s_q <= ovl_m_q;
         oc_m_q  <= overcurrent_i;
         oc_s_q  <= oc_m_q;
         sf_m_q  <= safe_fail_i;
         sf_s_q  <= sf_m_q;
         fb_m_q  <= switch_fb_i;
         fb_s_q  <= fb_m_q;
         sup_m_q <= supply_ok_i;
         sup_s_q <= sup_m_q;
      end
   end

   // ==========================================
   // bus decode
   function automatic logic [31:0] ofsr_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : ofsr_merge

   function automatic logic mode_ok(input logic [2:0] m);
      return (m <= 3'(ofsr_pkg::OFSR_MODE_SINK));
   endfunction : mode_ok

   localparam int IW = (N_OUT > 1) ? $clog2(N_OUT) : 1;
   wire          wr_stb   = avs_write_i & ~avs_waitrequest_o;
   wire          rd_stb   = avs_read_i & ~avs_waitrequest_o;
   wire          sel_stat = (avs_address_i[7:6] == 2'(`OFSR_STATUS_ADDR >> 6));
   wire          sel_ctl  = (avs_address_i[7:6] == 2'(`OFSR_CTRL_BASE >> 6));
   wire [5:0]    word_idx = {2'b00, avs_address_i[5:2]};
   wire          idx_ok   = (avs_address_i[1:0] == 2'b00) && (word_idx < 6'(N_OUT));
   wire [IW-1:0] idx      = IW'(word_idx);
   wire          sel_irqs = (avs_address_i == `OFSR_IRQ_STAT_ADDR);
   wire          sel_irqm = (avs_address_i == `OFSR_IRQ_MASK_ADDR);
   wire          sel_sup  = (avs_address_i == `OFSR_SUPPLY_ADDR);

   // ==========================================
   // per-output state
   logic [N_OUT-1:0] cmd_q, sw_req_q, ovl_q, safe_q, swoff_q, sup_flag_q, oc_lat_q;
   logic [2:0]       mode_q [N_OUT];
   ofsr_pkg::ofsr_ov_state_t ov_st_q [N_OUT];
   logic [N_OUT-1:0] ov_hold_done, sw_hold_done, sw_hold_run, ov_hold_run;
   logic [N_OUT-1:0] irq_stat_q, irq_mask_q;
   logic [N_OUT-1:0] ev_ovl, ev_swoff;

   wire all_off = ~|cmd_q;
   wire sup_bad = ~sup_s_q;

   genvar g;
   generate
      for (g = 0; g < N_OUT; g++) begin : g_out
         wire wr_me = wr_stb && sel_ctl && idx_ok && (idx == IW'(g));
         wire [31:0] ctl_cur = {27'h0, sw_req_q[g], mode_q[g], cmd_q[g]};
         wire [31:0] ctl_new = ofsr_merge(ctl_cur, avs_writedata_i, avs_byteenable_i);
         // overload trip as soon as it is seen while the output is in the run state, driven or not
         wire trip = ovl_s_q[g] && (ov_st_q[g] == ofsr_pkg::OFSR_OV_RUN); // [R1]
         assign ev_ovl[g]      = trip;
         assign ov_hold_run[g] = (ov_st_q[g] != ofsr_pkg::OFSR_OV_RUN) && !cmd_q[g]; // [R2]
         // the secondary drops its switch request while the switch is on
         assign ev_swoff[g]    = !swoff_q[g] && sw_req_q[g] && wr_me
                                 && !ctl_new[`OFSR_CTL_SW]; // [R12]
         assign sw_hold_run[g] = swoff_q[g];

         ofsr_hold_timer #(.CYCLES(HOLD_CYC)) u_ov_hold (
            .sys_clk_i (sys_clk_i),
            .resetn_i  (resetn_i),
            .run_i     (ov_hold_run[g]),
            .done_o    (ov_hold_done[g])
         );
         ofsr_hold_timer #(.CYCLES(HOLD_CYC)) u_sw_hold (
            .sys_clk_i (sys_clk_i),
            .resetn_i  (resetn_i),
            .run_i     (sw_hold_run[g]),
            .done_o    (sw_hold_done[g])
         );

         // switch may come back only after the hold and with the output commanded off
         wire sw_restore_ok = sw_hold_done[g] && !cmd_q[g]; // [R8] [R9]

         always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               cmd_q[g]      <= 1'b0;
               mode_q[g]     <= 3'h0;
               sw_req_q[g]   <= 1'b1;
               ovl_q[g]      <= 1'b0;
               safe_q[g]     <= 1'b0;
               swoff_q[g]    <= 1'b0;
               sup_flag_q[g] <= 1'b0;
               oc_lat_q[g]   <= 1'b0;
               ov_st_q[g]    <= ofsr_pkg::OFSR_OV_RUN;
            end else begin
               if (wr_me) begin
                  cmd_q[g]  <= ctl_new[`OFSR_CTL_CMD];
                  mode_q[g] <= ctl_new[`OFSR_CTL_MODE_HI:`OFSR_CTL_MODE_LO]; // [R5]
                  // a switch-on request is held back until restore is allowed
                  if (ctl_new[`OFSR_CTL_SW] && (!swoff_q[g] || sw_restore_ok)) begin
                     sw_req_q[g] <= 1'b1;
                  end else if (!ctl_new[`OFSR_CTL_SW]) begin
                     sw_req_q[g] <= 1'b0;
                  end
               end
               if (wr_me && swoff_q[g] && sw_restore_ok && ctl_new[`OFSR_CTL_SW]) begin
                  swoff_q[g] <= 1'b0; // [R9]
               end else if (ev_swoff[g]) begin
                  swoff_q[g] <= 1'b1; // [R7]
               end
               if (sf_s_q[g]) begin
                  safe_q[g] <= 1'b1; // [R6]
               end
               if (sup_bad) begin
                  sup_flag_q[g] <= 1'b1;
               end else if (all_off) begin
                  sup_flag_q[g] <= 1'b0; // [R11]
               end
               // closed-loop overcurrent latches until the command goes to zero
               if (oc_s_q[g] && mode_q[g] == 3'(ofsr_pkg::OFSR_MODE_CLOSED)) begin
                  oc_lat_q[g] <= 1'b1; // [R15]
               end else if (!cmd_q[g]) begin
                  oc_lat_q[g] <= 1'b0; // [R15]
               end
               case (ov_st_q[g])
                  ofsr_pkg::OFSR_OV_RUN: begin
                     if (trip) begin
                        ov_st_q[g] <= ofsr_pkg::OFSR_OV_TRIP;
                        ovl_q[g]   <= 1'b1; // [R1]
                     end
                  end
                  ofsr_pkg::OFSR_OV_TRIP: begin
                     if (!cmd_q[g]) begin
                        ov_st_q[g] <= ofsr_pkg::OFSR_OV_HOLD;
                     end
                  end
                  ofsr_pkg::OFSR_OV_HOLD: begin
                     if (cmd_q[g]) begin
                        ov_st_q[g] <= ofsr_pkg::OFSR_OV_TRIP;
                     end else if (ov_hold_done[g]) begin
                        ov_st_q[g] <= ofsr_pkg::OFSR_OV_RUN;
                        ovl_q[g]   <= 1'b0; // [R3]
                     end
                  end
                  default: begin
                     ov_st_q[g] <= ofsr_pkg::OFSR_OV_TRIP;
                  end
               endcase
            end
         end
      end
   endgenerate

   // ==========================================
   // output drive
   logic [N_OUT-1:0] mode_bad;
   always_comb begin
      for (int i = 0; i < N_OUT; i++) begin
         mode_bad[i] = !mode_ok(mode_q[i]); // [R4]
      end
   end
   // an output drives only with every guard clear and the safety switch read back on
   wire [N_OUT-1:0] drive_d = cmd_q & ~ovl_q & ~mode_bad & ~safe_q & ~oc_lat_q
                              & ~sup_flag_q & ~swoff_q & fb_s_q;
   wire [N_OUT-1:0] sw_d    = sw_req_q & ~swoff_q; // [R7] [R13]

   // ==========================================
   // interrupts and read mux
   wire [31:0] stat_word  = {23'h0, sup_flag_q[idx], swoff_q[idx], safe_q[idx],
                             mode_bad[idx], ovl_q[idx], 4'h0}; // [R16]
   wire [31:0] ctl_word   = {27'h0, sw_req_q[idx], mode_q[idx], cmd_q[idx]};
   wire [31:0] glob_word  = {8'h0, 8'(N_OUT), 8'(fb_s_q), 8'(sw_d)}; // [R13]
   wire [31:0] irq_s_word = 32'(irq_stat_q);
   wire [31:0] irq_m_word = 32'(irq_mask_q);
   wire [31:0] sup_word   = {31'h0, sup_s_q}; // [R14]
   wire [31:0] rd_mux     = (sel_stat && idx_ok) ? stat_word :
                            (sel_ctl && idx_ok)  ? ctl_word  :
                            (avs_address_i == `OFSR_GLOBAL_ADDR) ? glob_word :
                            sel_irqs ? irq_s_word :
                            sel_irqm ? irq_m_word :
                            sel_sup  ? sup_word   : 32'h0;
   wire [N_OUT-1:0] irq_w1c = (wr_stb && sel_irqs && avs_byteenable_i[0]) ?
                              avs_writedata_i[N_OUT-1:0] : '0;
   wire [N_OUT-1:0] irq_ev  = ev_ovl | ev_swoff;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         avs_waitrequest_o                 <= 1'b1;
         avs_readdata_o                    <= 32'h0;
         irq_stat_q                        <= '0;
         irq_mask_q                        <= '0;
         irq_o                             <= 1'b0;
         proportional_switched_output_en_o <= '0;
         safety_switch_o                   <= '0;
      end else begin
         // one wait cycle per access, so read data is registered
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
         if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rd_mux;
         end
         // a fresh event wins over a same-cycle clear
         irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_ev;
         if (wr_stb && sel_irqm && avs_byteenable_i[0]) begin
            irq_mask_q <= avs_writedata_i[N_OUT-1:0];
         end
         irq_o                             <= |(irq_stat_q & irq_mask_q);
         proportional_switched_output_en_o <= drive_d; // [R1] [R3] [R10]
         safety_switch_o                   <= sw_d;
      end
   end
   wire unused_ok = rd_stb;
endmodule : ofsr_top
`default_nettype wire

// file: verif/ofsr_stage_model.sv
// behavioural model of the redundant sourcing stages beside the block
`timescale 1ns/10ps
`default_nettype none
module ofsr_stage_model #(
   parameter int N_OUT = 4
) (
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   input  wire logic [N_OUT-1:0] safety_switch_i,
   output var  logic [N_OUT-1:0] switch_fb_o
);
   // ==========================================
   // feedback lags the switch one cycle, so the block never sees it early
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         switch_fb_o <= '0;
      end else begin
         switch_fb_o <= safety_switch_i;
      end
   end
endmodule : ofsr_stage_model
`default_nettype wire

// file: verif/ofsr_top_chk.sv
// concurrent checks on the ports of the output fault status block
`timescale 1ns/10ps
`default_nettype none
module ofsr_chk #(
   parameter int N_OUT    = 4,
   parameter int HOLD_CYC = 20
) (
   input wire logic             sys_clk_i,
   input wire logic             resetn_i,
   input wire logic [7:0]       avs_address_i,
   input wire logic             avs_read_i,
   input wire logic             avs_write_i,
   input wire logic [31:0]      avs_readdata_o,
   input wire logic             avs_waitrequest_o,
   input wire logic [N_OUT-1:0] overload_i,
   input wire logic [N_OUT-1:0] safe_fail_i,
   input wire logic [N_OUT-1:0] switch_fb_i,
   input wire logic             supply_ok_i,
   input wire logic [N_OUT-1:0] proportional_switched_output_en_o,
   input wire logic [N_OUT-1:0] safety_switch_o,
   input wire logic             irq_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // ==========================================
   // off time of switch 0; starts full so the release after reset passes
   logic [31:0] off_cnt_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) off_cnt_q <= 32'(HOLD_CYC);
      else if (safety_switch_o[0]) off_cnt_q <= 32'h0;
      else if (off_cnt_q < 32'(HOLD_CYC)) off_cnt_q <= off_cnt_q + 32'h1;
   end
   // ==========================================
   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low longer than one cycle");
   wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("access not answered in one cycle");
   ovl_off_a: assert property ((overload_i & $past(overload_i, 5) & proportional_switched_output_en_o) == '0)
      else $error("output driven during overload");
   safe_off_a: assert property ((safe_fail_i & $past(safe_fail_i, 5) & proportional_switched_output_en_o) == '0)
      else $error("output driven during safety failure");
   fb_off_a: assert property ((~switch_fb_i & ~$past(switch_fb_i, 5) & proportional_switched_output_en_o) == '0)
      else $error("output driven with switch open");
   supply_off_a: assert property (!supply_ok_i && !$past(supply_ok_i, 5) |-> proportional_switched_output_en_o == '0)
      else $error("output driven with supply bad");
   swoff_hold_a: assert property ($rose(safety_switch_o[0]) |-> off_cnt_q >= 32'(HOLD_CYC - 1))
      else $error("safety switch restored too early");
   stat_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i < 8'h40 |-> (avs_readdata_o & 32'hfffffe0f) == 32'h0)
      else $error("status reads ones outside flag field");
   sw_off_c: cover property ($fell(safety_switch_o[0]));
   irq_c: cover property ($rose(irq_o));
   drive_c: cover property ($rose(proportional_switched_output_en_o[0]));
endmodule : ofsr_chk
bind ofsr_top ofsr_chk #(.N_OUT(N_OUT), .HOLD_CYC(HOLD_CYC)) i_ofsr_chk (.sys_clk_i, .resetn_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .overload_i,
   .safe_fail_i, .switch_fb_i, .supply_ok_i, .proportional_switched_output_en_o,
   .safety_switch_o, .irq_o);
`default_nettype wire

// file: verif/ofsr_top_tb_top.sv
// self-checking bench for the output fault status block
`timescale 1ns/10ps
`default_nettype none
`include "ofsr_regs.svh"
module ofsr_top_tb_top;
   localparam int N    = 4;
   localparam int HOLD = 20;
   logic        clk, resetn, rd, wr, supply_ok, irq, waitreq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, q;
   logic [3:0]  be, ovl, oc, sfail, fb, en, sw;
   int          err_total, total_checks, i, k, j;
   ofsr_top #(.N_OUT(N), .HOLD_CYC(HOLD)) i_ofsr_top (.sys_clk_i(clk), .resetn_i(resetn),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .overload_i(ovl), .overcurrent_i(oc), .safe_fail_i(sfail), .switch_fb_i(fb),
      .supply_ok_i(supply_ok), .proportional_switched_output_en_o(en),
      .safety_switch_o(sw), .irq_o(irq));
   ofsr_stage_model #(.N_OUT(N)) i_ofsr_stage_model (.sys_clk_i(clk), .resetn_i(resetn),
      .safety_switch_i(sw), .switch_fb_o(fb));
   // ==========================================
   function automatic logic [31:0] ctl(input logic c, input logic [2:0] m, input logic s);
      return {27'h0, s, m, c};
   endfunction : ctl
   function automatic logic [31:0] exp_bad(input logic [2:0] m);
      return {31'h0, m > 3'h3};
   endfunction : exp_bad
   function automatic logic [31:0] bitq(input int b);
      return {31'h0, q[b]};
   endfunction : bitq
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // holds the request until waitrequest is sampled low, then releases
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      // no cycle count assumed: only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic stat(input int o);
      bus(1'b0, `OFSR_STATUS_ADDR + 8'(4 * o), 32'h0);
   endtask : stat
   task automatic wctl(input int o, input logic [31:0] d);
      bus(1'b1, `OFSR_CTRL_BASE + 8'(4 * o), d);
   endtask : wctl
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   // ==========================================
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   initial begin
      {resetn, rd, wr, addr, wdata, ovl, oc, sfail} = '0;
      be = 4'hf;
      supply_ok = 1'b1;
      err_total = 0;
      total_checks = 0;
      void'($urandom(32'hfb57f584));
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      idle(4);
      bus(1'b0, `OFSR_GLOBAL_ADDR, 32'h0);
      chk("outputs", 32'(N), {24'h0, q[23:16]});
      chk("switch readback", 32'hf0f, {20'h0, q[11:8], 4'h0, q[3:0]});
      bus(1'b0, `OFSR_SUPPLY_ADDR, 32'h0);
      chk("supply good", 32'h1, bitq(0));
      bus(1'b0, 8'hfc, 32'h0);
      chk("unmapped", 32'h0, q);
      for (j = 0; j < N; j++) wctl(j, ctl(1'b1, 3'h0, 1'b1));
      idle(8);
      chk("drive all", 32'hf, {28'h0, en});
      k = int'($urandom_range(N - 1));
      // last step goes invalid to valid
      for (j = 0; j < 9; j++) begin
         wctl(k, ctl(1'b1, 3'(j % 8), 1'b1));
         stat(k);
         chk("bad mode", exp_bad(3'(j % 8)), bitq(`OFSR_BIT_MODE));
      end
      i = int'($urandom_range(N - 1));
      bus(1'b1, `OFSR_IRQ_MASK_ADDR, 32'h1 << i);
      ovl[i] <= 1'b1;
      idle(8);
      ovl[i] <= 1'b0;
      idle(4);
      chk("ovl drive", 32'h0, {31'h0, en[i]});
      chk("irq raised", 32'h1, {31'h0, irq});
      stat(i);
      chk("ovl flag", 32'h1, bitq(`OFSR_BIT_OVL));
      bus(1'b1, `OFSR_IRQ_MASK_ADDR, 32'h0);
      idle(2);
      chk("irq masked", 32'h0, {31'h0, irq});
      wctl(i, ctl(1'b0, 3'h0, 1'b1));
      idle(14);
      // a command on inside the hold must restart it
      wctl(i, ctl(1'b1, 3'h0, 1'b1));
      wctl(i, ctl(1'b0, 3'h0, 1'b1));
      stat(i);
      chk("ovl hold restart", 32'h1, bitq(`OFSR_BIT_OVL));
      idle(HOLD + 5);
      stat(i);
      chk("ovl cleared", 32'h0, bitq(`OFSR_BIT_OVL));
      wctl(i, ctl(1'b1, 3'h0, 1'b1));
      idle(5);
      chk("ovl redrive", 32'h1, {31'h0, en[i]});
      bus(1'b0, `OFSR_IRQ_STAT_ADDR, 32'h0);
      chk("irq status", 32'h1, bitq(i));
      bus(1'b1, `OFSR_IRQ_STAT_ADDR, 32'h1 << i);
      bus(1'b0, `OFSR_IRQ_STAT_ADDR, 32'h0);
      chk("irq cleared", 32'h0, bitq(i));
      wctl(0, ctl(1'b1, 3'h0, 1'b0));
      idle(5);
      chk("switch off", 32'h0, {31'h0, sw[0]});
      chk("drive switch off", 32'h0, {31'h0, en[0]});
      stat(0);
      chk("switch flag", 32'h1, bitq(`OFSR_BIT_SWOFF));
      wctl(0, ctl(1'b0, 3'h0, 1'b0));
      wctl(0, ctl(1'b0, 3'h0, 1'b1));
      idle(2);
      chk("switch early", 32'h0, {31'h0, sw[0]});
      idle(HOLD);
      wctl(0, ctl(1'b0, 3'h0, 1'b1));
      idle(2);
      chk("switch back", 32'h1, {31'h0, sw[0]});
      wctl(0, ctl(1'b1, 3'h0, 1'b1));
      supply_ok <= 1'b0;
      idle(6);
      chk("supply drive", 32'h0, {28'h0, en});
      stat(k);
      chk("supply flag", 32'h1, bitq(`OFSR_BIT_SUPPLY));
      bus(1'b0, `OFSR_SUPPLY_ADDR, 32'h0);
      chk("supply bad", 32'h0, bitq(0));
      supply_ok <= 1'b1;
      idle(6);
      stat(k);
      chk("supply held", 32'h1, bitq(`OFSR_BIT_SUPPLY));
      for (j = 0; j < N; j++) wctl(j, ctl(1'b0, 3'h0, 1'b1));
      idle(4);
      stat(k);
      chk("supply clear", 32'h0, bitq(`OFSR_BIT_SUPPLY));
      // closed-loop overcurrent must stay latched after the current falls
      wctl(k, ctl(1'b1, 3'h2, 1'b1));
      oc[k] <= 1'b1;
      idle(6);
      oc[k] <= 1'b0;
      idle(6);
      chk("oc latched", 32'h0, {31'h0, en[k]});
      wctl(k, ctl(1'b0, 3'h2, 1'b1));
      wctl(k, ctl(1'b1, 3'h2, 1'b1));
      idle(5);
      chk("oc released", 32'h1, {31'h0, en[k]});
      sfail[k] <= 1'b1;
      idle(8);
      sfail[k] <= 1'b0;
      wctl(k, ctl(1'b1, 3'h0, 1'b1));
      idle(HOLD);
      stat(k);
      chk("safety flag", 32'h1, bitq(`OFSR_BIT_SAFE));
      resetn <= 1'b0;
      idle(5);
      resetn <= 1'b1;
      idle(4);
      stat(k);
      chk("safety reset", 32'h0, bitq(`OFSR_BIT_SAFE));
      print_verdict();
   end
endmodule : ofsr_top_tb_top
`default_nettype wire
